// ===== rtl/sadc_pkg.sv
// Shared constants for the serial ADC readout link
package sadc_pkg;
	localparam int SADC_BITS = 12;
	localparam int SADC_LEAD = 3;
	localparam logic [4:0] SADC_MSB_EDGE = 5'h03;
	localparam logic [4:0] SADC_LAST_EDGE = 5'h0e;
	localparam logic [4:0] SADC_MIN_EDGES = 5'h0f;
	localparam logic [4:0] SADC_CNT_RESET = 5'h00;
	localparam logic [11:0] SADC_RESULT_RESET = 12'h000;
	localparam int SADC_CLK_NS = 100;
	localparam int SADC_WAKE_NS = 2000000;
	localparam int SADC_WAKE_CYC = SADC_WAKE_NS / SADC_CLK_NS;
	localparam int SADC_CSW_NS = 100;
	localparam int SADC_CSW_CYC = (SADC_CSW_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
	localparam int SADC_ACQ_NS = 625;
	localparam int SADC_ACQ_CYC = (SADC_ACQ_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
	localparam int SADC_HALF_DIV = 4;
	localparam logic [7:0] SADC_DIV_RESET = 8'h00;
	localparam logic [21:0] SADC_WAIT_RESET = 22'h000000;
endpackage

// ===== rtl/sadc_if.sv
// Link wires between the converter and its host
interface sadc_if;
	logic sclk;
	logic cs_n;
	logic power_down_n;
	logic dout_o;
	logic dout_oe;
	logic dout;
	assign dout = dout_oe ? dout_o : 1'b1;
	modport dev (input sclk, input cs_n, input power_down_n, output dout_o, output dout_oe);
	modport host (output sclk, output cs_n, output power_down_n, input dout);
endinterface

// ===== rtl/sadc_device.sv
// Converter end: conversion sequencer and serial output on the link clock
module sadc_device
	import sadc_pkg::*;
(
	// Link
	sadc_if.dev lnk,
	// Analog input stand-in, sampled at select fall
	input wire logic [11:0] ain_code,
	input wire logic ain_valid,
	// Device reset on link side
	input wire logic rst
);
	typedef struct packed {
		logic [4:0] edges;
		logic [11:0] held;
		logic dout;
	} sadc_dev_t;

	sadc_dev_t s_reg;
	sadc_dev_t s_next;
	logic active;
	logic [11:0] held_new;

	// ******************************
	// Hold and start
	// ******************************
	assign active = lnk.power_down_n && !lnk.cs_n;

	// Sample frozen on each select fall; no clock needed
	always_ff @(negedge lnk.cs_n or posedge rst) begin
		if (rst) begin
			held_new <= SADC_RESULT_RESET;
		end else begin
			held_new <= ain_valid ? ain_code : SADC_RESULT_RESET;
		end
	end

	// ******************************
	// Shift on rising link clock
	// ******************************
	always_comb begin
		s_next = s_reg;
		s_next.held = held_new;
		if (s_reg.edges != SADC_MIN_EDGES) begin
			s_next.edges = s_reg.edges + 5'h01;
		end
		if (s_reg.edges + 5'h01 >= SADC_MSB_EDGE && s_reg.edges < SADC_LAST_EDGE) begin
			s_next.dout = s_reg.held[4'(SADC_LAST_EDGE - s_reg.edges - 5'h01)];
		end else begin
			s_next.dout = 1'b0;
		end
	end

	// Select high clears the sequence; an early rise aborts it
	always_ff @(posedge lnk.sclk or posedge rst or negedge active) begin
		if (rst) begin
			s_reg <= '0;
		end else if (!active) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign lnk.dout_o = s_reg.dout;
	assign lnk.dout_oe = active;
endmodule

// ===== rtl/sadc_host.sv
// Host end: makes the link clock, runs one read per request
module sadc_host
	import sadc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Requests
	input wire logic start,
	input wire logic two_byte,
	input wire logic power_up,
	// Answers
	output logic [11:0] result,
	output logic done,
	output logic busy,
	// Link
	sadc_if.host lnk
);
	typedef enum logic [2:0] {ST_WAKE, ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} sadc_st_t;
	typedef struct packed {
		sadc_st_t st;
		logic [21:0] wait_cnt;
		logic [7:0] div;
		logic [4:0] edges;
		logic [15:0] shift;
		logic [11:0] result;
		logic done;
		logic cs_n;
		logic sclk;
		logic pd_n;
		logic two_byte;
		logic d1;
		logic d2;
		logic busy;
	} sadc_host_t;

	sadc_host_t h_reg;
	sadc_host_t h_next;

	always_comb begin
		h_next = h_reg;
		h_next.d1 = lnk.dout;
		h_next.d2 = h_reg.d1;
		h_next.done = 1'b0;
		h_next.pd_n = power_up;
		if (!power_up) begin
			h_next.st = ST_WAKE;
			h_next.wait_cnt = SADC_WAIT_RESET;
			h_next.cs_n = 1'b1;
			h_next.sclk = 1'b0;
		end else begin
			unique case (h_reg.st)
				ST_WAKE: begin
					h_next.wait_cnt = h_reg.wait_cnt + 22'h1;
					if (h_reg.wait_cnt == 22'(SADC_WAKE_CYC - 1)) begin
						h_next.st = ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (start) begin
						h_next.st = ST_LOW;
						h_next.cs_n = 1'b0;
						h_next.div = SADC_DIV_RESET;
						h_next.edges = SADC_CNT_RESET;
						h_next.two_byte = two_byte;
					end
				end
				ST_LOW: begin
					h_next.div = h_reg.div + 8'h1;
					if (h_reg.div == 8'(SADC_HALF_DIV - 1)) begin
						h_next.div = SADC_DIV_RESET;
						h_next.sclk = 1'b1;
						h_next.st = ST_HIGH;
						// Sample what the previous rise launched
						if (h_reg.edges != SADC_CNT_RESET) begin
							h_next.shift = {h_reg.shift[14:0], h_reg.d2};
						end
						h_next.edges = h_reg.edges + 5'h01;
					end
				end
				ST_HIGH: begin
					h_next.div = h_reg.div + 8'h1;
					if (h_reg.div == 8'(SADC_HALF_DIV - 1)) begin
						h_next.div = SADC_DIV_RESET;
						h_next.sclk = 1'b0;
						if (h_reg.edges == (h_reg.two_byte ? SADC_MIN_EDGES + 5'h01 : SADC_MIN_EDGES)) begin
							h_next.cs_n = 1'b1;
							h_next.st = ST_GAP;
							h_next.wait_cnt = SADC_WAIT_RESET;
							h_next.result = h_reg.two_byte ? h_reg.shift[12:1] : h_reg.shift[11:0];
							h_next.done = 1'b1;
						end else begin
							h_next.st = ST_LOW;
						end
					end
				end
				ST_GAP: begin
					h_next.wait_cnt = h_reg.wait_cnt + 22'h1;
					if (h_reg.wait_cnt == 22'(SADC_ACQ_CYC)) begin
						h_next.st = ST_IDLE;
					end
				end
			endcase
		end
		// Kept as a flop so the output carries no decode glitches
		h_next.busy = h_next.st != ST_IDLE;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			h_reg <= '{st: ST_WAKE, cs_n: 1'b1, busy: 1'b1, default: '0};
		end else begin
			h_reg <= h_next;
		end
	end

	assign lnk.sclk = h_reg.sclk;
	assign lnk.cs_n = h_reg.cs_n;
	assign lnk.power_down_n = h_reg.pd_n;
	assign result = h_reg.result;
	assign done = h_reg.done;
	assign busy = h_reg.busy;
endmodule

// ===== test/sadc_assertions.sv
// Link checks between host and converter ends
module sadc_assertions
	import sadc_pkg::*;
(
	// Host clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic power_down_n,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic sclk_q;
	logic [4:0] edges;
	logic [21:0] wake;
	// Rises so far, this one included
	wire logic [4:0] n = edges + {4'h0, sclk & ~sclk_q};
	// Link clock is made from clk, so plain sampling is safe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			edges <= 5'h00;
			wake <= 22'h000000;
		end else begin
			sclk_q <= sclk;
			edges <= cs_n ? 5'h00 : n;
			wake <= power_down_n ? wake + {21'h0, ~&wake} : 22'h000000;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_start; $fell(cs_n); endsequence
	sequence s_low; dout_oe && !dout_o; endsequence
	a_idle_released: assert property (cs_n |-> !dout_oe) else $error("oe while deselected");
	a_start_low: assert property (s_start |=> s_low) else $error("no low after select");
	a_change_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |-> $rose(sclk))
		else $error("dout moved off rise");
	a_lead_zeros: assert property (dout_oe && n < 5'h03 |-> !dout_o) else $error("lead not zero");
	a_trail_zeros: assert property (dout_oe && n > 5'h0e |-> !dout_o) else $error("trail not zero");
	a_raise_late: assert property ($rose(cs_n) |-> edges >= 5'h0f) else $error("select rose early");
	a_high_gap: assert property ($rose(cs_n) |-> cs_n [*7]) else $error("select gap short");
	a_wake_wait: assert property (s_start |-> wake >= SADC_WAKE_CYC - 2) else $error("start too soon");
	a_down_quiet: assert property (!power_down_n |-> cs_n && !dout_oe) else $error("active when down");
	a_sclk_idle: assert property (cs_n |-> !sclk) else $error("sclk not idle low");
endmodule

// ===== test/tb_serial_adc_conversion_readout.sv
// Bench for the host and converter ends joined by the link
module tb_serial_adc_conversion_readout;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic two_byte = 1'b0;
	logic power_up = 1'b1;
	logic ain_valid = 1'b1;
	logic [11:0] ain_code = 12'h000;
	logic [11:0] result;
	logic done;
	logic busy;
	logic [15:0] sh = 16'h0000;
	int fails = 0;
	int cmp_count = 0;
	sadc_if lnk ();
	always #50 clk = ~clk;
	sadc_host sadc_host_i (.clk(clk), .rst(rst), .start(start), .two_byte(two_byte), .power_up(power_up),
		.result(result), .done(done), .busy(busy), .lnk(lnk));
	sadc_device sadc_device_i (.lnk(lnk), .ain_code(ain_code), .ain_valid(ain_valid), .rst(rst));
	sadc_assertions sadc_assertions_i (.clk(clk), .rst(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
		.power_down_n(lnk.power_down_n), .dout_o(lnk.dout_o), .dout_oe(lnk.dout_oe));
	// Wire sampled 20 ns into the high phase, clear of the update at the rise
	always @(posedge lnk.sclk) begin
		#20 sh = {sh[14:0], lnk.dout};
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic step(input int k);
		for (int i = 0; i < k; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic go();
		for (int i = 0; i < 30000 && busy !== 1'b0; i++) step(1);
		step(1);
		start = 1'b1;
		step(1);
		start = 1'b0;
	endtask
	task automatic t_read(input logic [11:0] code, input logic mode);
		logic [11:0] e;
		e = code & {12{ain_valid}};
		two_byte = mode;
		ain_code = code;
		sh = 16'h0000;
		go();
		// Input moves once held; the result must not follow
		ain_code = ~code;
		for (int i = 0; i < 300 && done !== 1'b1; i++) step(1);
		chk({4'h0, result}, {4'h0, e});
		chk(sh, mode ? {2'b00, e, 2'b00} : {3'b000, e, 1'b0});
	endtask
	task automatic t_asleep();
		step(20);
		power_up = 1'b0;
		step(4);
		// Request while powered down must be refused
		start = 1'b1;
		step(1);
		start = 1'b0;
		step(50);
		chk({14'h0000, lnk.cs_n, lnk.dout}, 16'h0003);
		chk({15'h0000, busy}, 16'h0001);
		power_up = 1'b1;
	endtask
	initial begin
		step(5);
		rst = 1'b0;
		t_read(12'hfff, 1'b0);
		t_read(12'ha5c, 1'b0);
		t_read(12'h801, 1'b1);
		t_read(12'h000, 1'b1);
		ain_valid = 1'b0;
		t_read(12'h3c3, 1'b0);
		ain_valid = 1'b1;
		t_asleep();
		t_read(12'h5a7, 1'b1);
		conclude();
	end
	initial begin
		step(60000);
		fails++;
		conclude();
	end
endmodule
